// File: rtl/mctu_core.sv
// Purpose: combination mode, output level control, five channel counters
// Assumes: count, clear, capture strobes arrive one-cycle from the channels
// Notes:
// Notes on behaviour
// - function control resets to initial value, standby too
// - function bit 6 reads one, bit 7
// - bits 5..4 select normal, complementary, reset-sync
// - combination mode overrides channel 3/4 pwm bits
// - bits 3..0 enable buffer mode per pair
// - level control resets to direct output
// - level bits 6..2 read one, bit 7
// - level selects act only in combined modes
// - hi select zero inverts 3a, 4a, 4b
// - lo select zero inverts 3b, 4 complementary
// - five 16-bit counters stepped by count ticks; prescaler select unused
// - counters 0,1 up; 2,3,4 up/down in modes
// - clear on match or capture when enabled
// - up wrap sets wrap flag
// - down wrap also sets wrap flag
// - counters word or byte accessible
// - counters clear on reset and standby
// - channel 2 wrap condition select gates underflow
`timescale 1ns/1ns
module mctu_core #(
  parameter int unsigned CH = mctu_pkg::NUM_CH,
  parameter int unsigned W = mctu_pkg::CNT_W
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic standby_i,
  // cpu access
  input wire mctu_pkg::mctu_cpu_t cpu_i,
  output logic [15:0] cpu_rdata_o,
  // channel controls from neighbouring registers
  input wire logic [CH-1:0][2:0] prescaler_select_i,
  input wire logic [CH-1:0] count_tick_i,
  input wire logic [CH-1:0] count_down_i,
  input wire logic phase_count_ch2_i,
  input wire logic wrap_condition_select_i,
  input wire logic pwm_select_ch3_i,
  input wire logic pwm_select_ch4_i,
  input wire logic [CH-1:0] clear_en_i,
  input wire logic [CH-1:0] match_or_capture_i,
  // raw waveforms from channels 3 and 4
  input wire mctu_pkg::mctu_pins_t wave_i,
  // results
  output mctu_pkg::mctu_pins_t pins_o,
  output logic [CH-1:0] wrap_flag_set_o,
  output logic [CH-1:0][15:0] channel_counter_o,
  output logic [1:0] pwm_eff_o,
  output logic comp_mode_o,
  output logic rsync_mode_o,
  output logic [3:0] buffer_enable_o
);
  initial
  begin
    if (CH != 5 || W != 16)
      $error("mctu_core serves five 16-bit channels only");
  end

  mctu_pkg::mctu_state_t st_r;
  mctu_pkg::mctu_state_t st_nxt;
  logic [CH-1:0] wrap_nxt;
  logic [CH-1:0] wrap_r;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] merge_bytes(input logic [15:0] old,
    input logic [15:0] wd, input logic [1:0] be);
    logic [15:0] res;
    res = old;
    if (be[1])
      res[15:8] = wd[15:8];
    if (be[0])
      res[7:0] = wd[7:0];
    return res;
  endfunction

  function automatic logic hits(input mctu_pkg::mctu_cpu_t c,
    input logic [3:0] sel);
    return c.wr && c.sel == sel;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic comb_on;
  logic comp_mode;
  assign comp_mode = st_r.cmb == mctu_pkg::MCTU_CMB_COMP;
  assign comb_on = comp_mode || st_r.cmb == mctu_pkg::MCTU_CMB_RSYNC;

  always_comb
  begin
    logic [15:0] cv;
    logic dn;
    logic [7:0] fw;
    logic [7:0] ow;
    cv = '0;
    dn = 1'b0;
    fw = '0;
    ow = '0;
    st_nxt = st_r;
    wrap_nxt = '0;
    // only writable fields are kept; fixed bits never stored
    if (hits(cpu_i, mctu_pkg::SEL_FUNC) && cpu_i.be[0])
    begin
      fw = cpu_i.wdata[7:0];
      st_nxt.cmb = mctu_pkg::mctu_cmb_t'(fw[mctu_pkg::FC_CMB_POS +: 2]);
      st_nxt.buf_en = fw[mctu_pkg::FC_BUF_POS +: 4];
    end
    if (hits(cpu_i, mctu_pkg::SEL_OUTL) && cpu_i.be[0])
    begin
      ow = cpu_i.wdata[7:0];
      st_nxt.level_select_hi = ow[mctu_pkg::OL_HI_POS];
      st_nxt.level_select_lo = ow[mctu_pkg::OL_LO_POS];
    end
    for (int i = 0; i < 5; i++)
    begin
      cv = st_r.cnt[i];
      // direction only honoured where the mode allows it
      dn = count_down_i[i] && ((i == 2 && phase_count_ch2_i) ||
           (i >= 3 && comp_mode));
      if (clear_en_i[i] && match_or_capture_i[i])
        st_nxt.cnt[i] = mctu_pkg::CNT_RESET;
      else if (count_tick_i[i])
      begin
        if (dn)
        begin
          st_nxt.cnt[i] = cv - 16'h0001;
          wrap_nxt[i] = cv == mctu_pkg::CNT_RESET &&
            !(i == 2 && wrap_condition_select_i);
        end
        else
        begin
          st_nxt.cnt[i] = cv + 16'h0001;
          wrap_nxt[i] = cv == mctu_pkg::CNT_ALL_ONES;
        end
      end
      if (hits(cpu_i, mctu_pkg::SEL_CNT0 + 4'(i)))
      begin
        st_nxt.cnt[i] = merge_bytes(cv, cpu_i.wdata, cpu_i.be);
        wrap_nxt[i] = 1'b0;
      end
    end
    // read data, fixed ones forced, undefined bit 7 reads one
    st_nxt.rdata = '0;
    if (cpu_i.rd)
    begin
      if (cpu_i.sel == mctu_pkg::SEL_FUNC)
        st_nxt.rdata = {8'h00, mctu_pkg::FC_RESET | {2'b00,
          2'(st_r.cmb), st_r.buf_en}};
      else if (cpu_i.sel == mctu_pkg::SEL_OUTL)
        st_nxt.rdata = {8'h00, mctu_pkg::FC_RESET | mctu_pkg::OL_FIXED_ONES |
          {6'h00, st_r.level_select_hi, st_r.level_select_lo}};
      else if (cpu_i.sel >= mctu_pkg::SEL_CNT0 &&
               cpu_i.sel < mctu_pkg::SEL_CNT0 + 4'h5)
        st_nxt.rdata = st_r.cnt[3'(cpu_i.sel - mctu_pkg::SEL_CNT0)];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= '{cmb: mctu_pkg::MCTU_CMB_NORM0, buf_en: 4'h0,
                level_select_hi: 1'b1, level_select_lo: 1'b1,
                cnt: '0, rdata: 16'h0000};
      wrap_r <= '0;
    end
    else if (standby_i)
    begin
      st_r <= '{cmb: mctu_pkg::MCTU_CMB_NORM0, buf_en: 4'h0,
                level_select_hi: 1'b1, level_select_lo: 1'b1,
                cnt: '0, rdata: 16'h0000};
      wrap_r <= '0;
    end
    else if (clk_en_i)
    begin
      st_r <= st_nxt;
      wrap_r <= wrap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins registered so polarity switches glitch free
  mctu_pkg::mctu_pins_t pins_r;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pins_r <= '0;
    else if (clk_en_i)
    begin
      pins_r <= wave_i;
      if (comb_on)
      begin
        pins_r.ch3_out_a <= wave_i.ch3_out_a ^ !st_r.level_select_hi;
        pins_r.ch4_out_a <= wave_i.ch4_out_a ^ !st_r.level_select_hi;
        pins_r.ch4_out_b <= wave_i.ch4_out_b ^ !st_r.level_select_hi;
        pins_r.ch3_out_b <= wave_i.ch3_out_b ^ !st_r.level_select_lo;
        pins_r.ch4_comp_out_a <= wave_i.ch4_comp_out_a ^
          !st_r.level_select_lo;
        pins_r.ch4_comp_out_b <= wave_i.ch4_comp_out_b ^
          !st_r.level_select_lo;
      end
    end
  end

  assign pins_o = pins_r;
  assign cpu_rdata_o = st_r.rdata;
  assign wrap_flag_set_o = wrap_r;
  assign channel_counter_o = st_r.cnt;
  // combined mode masks individual pwm selects
  assign pwm_eff_o = comb_on ? 2'b00 :
    {pwm_select_ch4_i, pwm_select_ch3_i};
  assign comp_mode_o = comp_mode;
  assign rsync_mode_o = st_r.cmb == mctu_pkg::MCTU_CMB_RSYNC;
  assign buffer_enable_o = st_r.buf_en;

  ////////////////////////////////////////////////////////////////////////
  a_up_wrap_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && !cpu_i.wr && count_tick_i[0] &&
    !(clear_en_i[0] && match_or_capture_i[0]) &&
    st_r.cnt[0] == 16'hffff |=> wrap_r[0] && st_r.cnt[0] == 16'h0000)
    else $error("up wrap not flagged");
  a_down_wrap_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && !cpu_i.wr && count_tick_i[3] &&
    count_down_i[3] && comp_mode && !(clear_en_i[3] && match_or_capture_i[3])
    && st_r.cnt[3] == 16'h0000 |=> wrap_r[3] && st_r.cnt[3] == 16'hffff)
    else $error("down wrap not flagged");
  a_ch2_wrap_cond: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && wrap_condition_select_i && count_down_i[2] && phase_count_ch2_i
    |=> !wrap_r[2])
    else $error("underflow flagged with overflow-only");
  a_clear_on_match: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !cpu_i.wr && clear_en_i[1] && match_or_capture_i[1]
    |=> st_r.cnt[1] == 16'h0000)
    else $error("counter not cleared");
  a_cpu_write_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && cpu_i.wr && cpu_i.sel == mctu_pkg::SEL_CNT0 &&
    cpu_i.be == 2'b11 |=> st_r.cnt[0] == $past(cpu_i.wdata))
    else $error("cpu write lost");
  a_up_only_ch0: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && !cpu_i.wr && count_tick_i[0] &&
    !(clear_en_i[0] && match_or_capture_i[0])
    |=> st_r.cnt[0] == $past(st_r.cnt[0]) + 16'h0001)
    else $error("counter 0 not counting up");
  a_fixed_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && cpu_i.rd && cpu_i.sel == mctu_pkg::SEL_OUTL
    |=> cpu_rdata_o[7:2] == 6'h3f)
    else $error("fixed level bits not one");
  a_standby_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    standby_i |=> st_r.cnt == '0 && st_r.level_select_hi &&
    st_r.cmb == mctu_pkg::MCTU_CMB_NORM0)
    else $error("standby did not initialise");
  a_level_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !comb_on |=> pins_r == $past(wave_i))
    else $error("level select acted outside combined modes");
  a_pwm_override: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    comb_on |-> pwm_eff_o == 2'b00)
    else $error("pwm select not overridden");

  ////////////////////////////////////////////////////////////////////////
  // steps shared by the counter checks below
  sequence s_active;
    clk_en_i && !standby_i && !cpu_i.wr;
  endsequence

  sequence s_tick3_free;
    count_tick_i[3] && !(clear_en_i[3] && match_or_capture_i[3]);
  endsequence

  sequence s_tick4_free;
    count_tick_i[4] && !(clear_en_i[4] && match_or_capture_i[4]);
  endsequence

  // a low enable must hold every counter, whatever the strobes do
  a_freeze_counts: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !clk_en_i && !standby_i |=> st_r.cnt == $past(st_r.cnt))
    else $error("counters moved while enable low");
  // reset-sync mode gives no down count on channel 3
  a_rsync_up_only: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    s_active ##0 s_tick3_free ##0 (st_r.cmb == mctu_pkg::MCTU_CMB_RSYNC)
    |=> st_r.cnt[3] == $past(st_r.cnt[3]) + 16'h0001)
    else $error("counter 3 not counting up");
  a_ch4_down_comp: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    s_active ##0 s_tick4_free ##0 (comp_mode && count_down_i[4])
    |=> st_r.cnt[4] == $past(st_r.cnt[4]) - 16'h0001)
    else $error("counter 4 not counting down");
  a_buffer_write: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    clk_en_i && !standby_i && cpu_i.wr && cpu_i.sel == mctu_pkg::SEL_FUNC &&
    cpu_i.be[0] |=> st_r.buf_en == $past(cpu_i.wdata[3:0]))
    else $error("buffer enables not written");
  a_func_fixed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && !standby_i && cpu_i.rd && cpu_i.sel == mctu_pkg::SEL_FUNC
    |=> cpu_rdata_o[7:6] == 2'b11)
    else $error("fixed function bits not one");
  a_hi_inverts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && comb_on && !st_r.level_select_hi
    |=> pins_r.ch3_out_a != $past(wave_i.ch3_out_a))
    else $error("hi level select did not invert");
  a_lo_inverts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    clk_en_i && comb_on && !st_r.level_select_lo
    |=> pins_r.ch3_out_b != $past(wave_i.ch3_out_b))
    else $error("lo level select did not invert");
  // standby must also drop buffers and restore direct output
  a_standby_level: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    standby_i |=> st_r.level_select_lo && st_r.buf_en == 4'h0)
    else $error("standby left level or buffer bits");
endmodule

// File: rtl/mctu_pkg.sv
// Purpose: shared constants and carriers for the timer combination block
// Assumes: 8-bit byte lanes on a 16-bit cpu data path
// Notes: register selects are local indices of this block
package mctu_pkg;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PSC_W = 3;
  // register selects
  localparam logic [3:0] SEL_FUNC = 4'h0;
  localparam logic [3:0] SEL_OUTL = 4'h1;
  localparam logic [3:0] SEL_CNT0 = 4'h2;
  // function control fields
  localparam int unsigned FC_RSV1_POS = 6;
  localparam int unsigned FC_CMB_POS = 4;
  localparam int unsigned FC_BUF_POS = 0;
  localparam logic [7:0] FC_RESET = 8'hc0;
  localparam logic [7:0] FC_FIXED_ONES = 8'h40;
  // output level control fields
  localparam int unsigned OL_HI_POS = 1;
  localparam int unsigned OL_LO_POS = 0;
  localparam logic [7:0] OL_RESET = 8'hff;
  localparam logic [7:0] OL_FIXED_ONES = 8'h7c;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hffff;

  typedef enum logic [1:0] {
    MCTU_CMB_NORM0,
    MCTU_CMB_NORM1,
    MCTU_CMB_COMP,
    MCTU_CMB_RSYNC
  } mctu_cmb_t;

  // cpu access carrier
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] sel;
    logic [1:0] be;
    logic [15:0] wdata;
  } mctu_cpu_t;

  // six waveform pins of channels 3 and 4
  typedef struct packed {
    logic ch3_out_a;
    logic ch3_out_b;
    logic ch4_out_a;
    logic ch4_out_b;
    logic ch4_comp_out_a;
    logic ch4_comp_out_b;
  } mctu_pins_t;

  typedef struct packed {
    mctu_cmb_t cmb;
    logic [3:0] buf_en;
    logic level_select_hi;
    logic level_select_lo;
    logic [4:0][15:0] cnt;
    logic [15:0] rdata;
  } mctu_state_t;
endpackage

// File: dv/tb.sv
// Purpose: self-checking bench for the timer combination block
// Assumes: design assertions live in the rtl files
// Notes: register reads compare the low byte of control registers only
`timescale 1ns/1ns
module tb;
  logic clk_i, reset_n_i, clk_en_i, standby_i;
  mctu_pkg::mctu_cpu_t cpu_i;
  logic [15:0] rdata, d;
  logic [4:0][2:0] psc;
  logic [4:0] tick, down, clr_en, mc, wrap_set;
  logic ph2, wsel, pw3, pw4, comp, rsync;
  mctu_pkg::mctu_pins_t wave, pins;
  logic [4:0][15:0] cnt;
  logic [1:0] pwm_eff;
  logic [3:0] buf_en;
  int n_errors, checks_done, cyc;
  mctu_core u_mctu_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .standby_i(standby_i), .cpu_i(cpu_i),
    .cpu_rdata_o(rdata), .prescaler_select_i(psc), .count_tick_i(tick),
    .count_down_i(down), .phase_count_ch2_i(ph2),
    .wrap_condition_select_i(wsel), .pwm_select_ch3_i(pw3),
    .pwm_select_ch4_i(pw4), .clear_en_i(clr_en),
    .match_or_capture_i(mc), .wave_i(wave), .pins_o(pins),
    .wrap_flag_set_o(wrap_set), .channel_counter_o(cnt),
    .pwm_eff_o(pwm_eff), .comp_mode_o(comp), .rsync_mode_o(rsync),
    .buffer_enable_o(buf_en));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] s, input logic [1:0] b,
                        input logic [15:0] v);
    @(posedge clk_i);
    cpu_i <= {1'b0, 1'b1, s, b, v};
    @(posedge clk_i);
    cpu_i <= '0;
  endtask
  // control registers are byte wide: only the low lane is compared
  task automatic rdchk(input logic [3:0] s, input logic [15:0] exp,
                       input bit full);
    @(posedge clk_i);
    cpu_i <= {1'b1, 1'b0, s, 2'b11, 16'h0000};
    @(posedge clk_i);
    cpu_i <= '0;
    #1;
    d = full ? rdata : {8'h00, rdata[7:0]};
    check(d, exp);
  endtask
  task automatic pulse(input logic [4:0] t, input logic [4:0] m);
    @(posedge clk_i);
    tick <= t;
    mc <= m;
    @(posedge clk_i);
    tick <= '0;
    mc <= '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // stuck run guard, far above the fewer than a hundred cycles needed
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    reset_n_i = 1'b0; clk_en_i = 1'b1; standby_i = 1'b0; cpu_i = '0;
    psc = '0; tick = '0; down = '0; clr_en = '0; mc = '0; ph2 = 1'b0;
    wsel = 1'b0; pw3 = 1'b1; pw4 = 1'b1; wave = 6'h3f;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk(mctu_pkg::SEL_FUNC, 16'h00c0, 0);
    rdchk(mctu_pkg::SEL_OUTL, 16'h00ff, 0);
    for (int i = 0; i < 5; i++)
      rdchk(mctu_pkg::SEL_CNT0 + 4'(i), 16'h0000, 1);
    // every combination code, reserved bits written as zero
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(mctu_pkg::SEL_FUNC, 2'b01, 16'((m << 4) | (1 << m)));
      rdchk(mctu_pkg::SEL_FUNC, 16'(8'hc0 | (m << 4) | (1 << m)), 0);
      check({14'h0, comp, rsync}, m == 2 ? 2 : m == 3 ? 1 : 0);
      check({14'h0, pwm_eff}, m >= 2 ? 0 : 3);
      check({12'h0, buf_en}, 16'(1 << m));
    end
    reg_wr(mctu_pkg::SEL_OUTL, 2'b01, 16'h0001);
    rdchk(mctu_pkg::SEL_OUTL, 16'h00fd, 0);
    repeat (2) @(posedge clk_i);
    #1 check({10'h0, pins}, 16'h0013);
    reg_wr(mctu_pkg::SEL_OUTL, 2'b01, 16'h0002);
    repeat (2) @(posedge clk_i);
    #1 check({10'h0, pins}, 16'h002c);
    reg_wr(mctu_pkg::SEL_FUNC, 2'b01, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1 check({10'h0, pins}, 16'h003f);
    // counters: wrap, byte lanes, direction, clear
    reg_wr(mctu_pkg::SEL_CNT0, 2'b11, 16'hffff);
    pulse(5'h01, 5'h00);
    check(cnt[0], 16'h0000);
    check({11'h0, wrap_set}, 16'h0001);
    reg_wr(mctu_pkg::SEL_CNT0 + 4'h1, 2'b10, 16'hab12);
    reg_wr(mctu_pkg::SEL_CNT0 + 4'h1, 2'b01, 16'h0034);
    rdchk(mctu_pkg::SEL_CNT0 + 4'h1, 16'hab34, 1);
    @(posedge clk_i);
    down <= 5'h1f;
    ph2 <= 1'b1;
    pulse(5'h01, 5'h00);
    check(cnt[0], 16'h0001);
    pulse(5'h04, 5'h00);
    check(cnt[2], 16'hffff);
    check({11'h0, wrap_set}, 16'h0004);
    reg_wr(mctu_pkg::SEL_CNT0 + 4'h2, 2'b11, 16'h0000);
    wsel <= 1'b1;
    pulse(5'h04, 5'h00);
    check({11'h0, wrap_set}, 16'h0000);
    reg_wr(mctu_pkg::SEL_FUNC, 2'b01, 16'h0060);
    pulse(5'h08, 5'h00);
    check(cnt[3], 16'hffff);
    clr_en <= 5'h1f;
    pulse(5'h00, 5'h02);
    check(cnt[1], 16'h0000);
    // cpu write, count tick and clear strobe land on the same edge
    @(posedge clk_i);
    cpu_i <= {1'b0, 1'b1, mctu_pkg::SEL_CNT0 + 4'h4, 2'b11, 16'h1234};
    tick <= 5'h10;
    mc <= 5'h10;
    @(posedge clk_i);
    cpu_i <= '0;
    tick <= '0;
    mc <= '0;
    #1 check(cnt[4], 16'h1234);
    // enable low must freeze a ticking counter
    clk_en_i <= 1'b0;
    pulse(5'h01, 5'h00);
    check(cnt[0], 16'h0001);
    clk_en_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    #1;
    for (int i = 0; i < 5; i++)
      check(cnt[i], 16'h0000);
    rdchk(mctu_pkg::SEL_FUNC, 16'h00c0, 0);
    rdchk(mctu_pkg::SEL_OUTL, 16'h00ff, 0);
    results();
  end
endmodule
